/* shared/calr_pkg.sv */
// shared constants and carrier types for the calibration register access block
package calr_pkg;

  // register file shape
  localparam int CAL_COUNT = 10;
  localparam int IDX_W     = 4;
  localparam int DATA_W    = 14;

  // pointer positions: gain, offset, then eight dac words
  localparam logic [3:0] IDX_GAIN     = 4'h0;
  localparam logic [3:0] IDX_OFFSET   = 4'h1;
  localparam logic [3:0] IDX_DAC_LAST = 4'h9;

  // calibration group select codes {hi, lo}
  localparam logic [1:0] GRP_ALL      = 2'h0;
  localparam logic [1:0] GRP_GAIN_OFF = 2'h1;
  localparam logic [1:0] GRP_OFF      = 2'h2;
  localparam logic [1:0] GRP_GAIN     = 2'h3;

  // read path select codes {hi, lo}
  localparam logic [1:0] RDSEL_CAL    = 2'h2;
  localparam logic [1:0] RDSEL_STATUS = 2'h3;

  // control low byte field positions
  localparam int CTL_RDSEL_LO = 0;
  localparam int CTL_RDSEL_HI = 1;
  localparam int CTL_GRP_LO   = 2;
  localparam int CTL_GRP_HI   = 3;
  localparam int CTL_CONV     = 4;
  localparam int CTL_CAL      = 5;

  // reset contents of the correction words
  localparam logic [13:0] GAIN_RESET   = 14'h2000;
  localparam logic [13:0] OFFSET_RESET = 14'h2000;
  localparam logic [13:0] DAC_RESET    = 14'h0000;

  // status word layout
  localparam logic [15:0] ST_ONES  = 16'h00C0;
  localparam int          ST_STCAL = 0;
  localparam int          ST_GRPLO = 1;
  localparam int          ST_GRPHI = 2;
  localparam int          ST_BUSY  = 4;

  // live control selections
  typedef struct packed {
    logic [1:0] read_sel;
    logic [1:0] cal_group;
  } calr_ctrl_s;

  localparam calr_ctrl_s CTRL_RESET = '{read_sel: 2'h0, cal_group: 2'h0};

  // update port from the calibration engine
  typedef struct packed {
    logic        valid;
    logic [3:0]  index;
    logic [13:0] data;
  } calr_upd_s;

endpackage

/* hdl/calr_pointer.sv */
// calibration register pointer: first, last and wrap per selected group
`timescale 1ns/1ns
`default_nettype none
module calr_pointer (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // selection and events
  input  wire logic [1:0] group,
  input  wire logic       restart,
  input  wire logic       advance,
  // pointer state
  output logic      [3:0] index,
  output logic            at_last
);

  // first word of a group: offset alone starts at offset
  function automatic logic [3:0] first_of(input logic [1:0] g);
    first_of = (g == calr_pkg::GRP_OFF) ? calr_pkg::IDX_OFFSET : calr_pkg::IDX_GAIN;
  endfunction

  // last word of a group; full group runs through all ten
  function automatic logic [3:0] last_of(input logic [1:0] g);
    case (g)
      calr_pkg::GRP_ALL:      last_of = calr_pkg::IDX_DAC_LAST;
      calr_pkg::GRP_GAIN_OFF: last_of = calr_pkg::IDX_OFFSET;
      calr_pkg::GRP_OFF:      last_of = calr_pkg::IDX_OFFSET;
      default:                last_of = calr_pkg::IDX_GAIN;
    endcase
  endfunction

  // wrap point for the current group
  assign at_last = (index == last_of(group));

  // restart beats advance; wrapping restores the first word
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      index <= calr_pkg::IDX_GAIN;
    end else if (restart) begin
      index <= first_of(group);
    end else if (advance) begin
      index <= at_last ? first_of(group) : index + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_wrap;
    advance && at_last && !restart |=> index == first_of(group);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap to first");

  property p_step;
    advance && !at_last && !restart |=> index == $past(index) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step by one");

  property p_in_group;
    $stable(group) |-> index <= last_of(group);
  endproperty
  a_in_group: assert property (p_in_group) else $error("pointer left its group");

endmodule
`default_nettype wire

/* hdl/calr_regfile.sv */
// ten 14-bit correction words with host and calibration engine write ports
`timescale 1ns/1ns
`default_nettype none
module calr_regfile #(
  parameter int COUNT = calr_pkg::CAL_COUNT
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // host write port
  input  wire logic                 wr_en,
  input  wire logic        [3:0]    wr_idx,
  input  wire logic        [13:0]   wr_data,
  // engine update port
  input  wire calr_pkg::calr_upd_s  upd,
  // read port
  input  wire logic        [3:0]    rd_idx,
  output logic             [13:0]   rd_data
);

  logic [13:0] ent [16]; // word views, unused slots read zero

  // one storage word per entry below COUNT
  for (genvar g = 0; g < 16; g++) begin : g_ent
    if (g < COUNT) begin : g_live
      localparam logic [13:0] RV = (g == 0) ? calr_pkg::GAIN_RESET :
                                   (g == 1) ? calr_pkg::OFFSET_RESET : calr_pkg::DAC_RESET;
      wire logic host_hit = wr_en && (wr_idx == 4'(g));
      wire logic eng_hit  = upd.valid && (upd.index == 4'(g));
      logic [13:0] q; // stored correction data

      // engine wins: a running calibration owns the words
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          q <= RV;
        end else if (eng_hit) begin
          q <= upd.data;
        end else if (host_hit) begin
          q <= wr_data;
        end
      end
      assign ent[g] = q;
    end else begin : g_none
      assign ent[g] = 14'h0000;
    end
  end

  // all entries readable
  assign rd_data = ent[rd_idx];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_eng_store;
    upd.valid && upd.index < 4'(COUNT) |=> ent[$past(upd.index)] == $past(upd.data);
  endproperty
  a_eng_store: assert property (p_eng_store) else $error("engine update lost");

  property p_host_store;
    wr_en && !upd.valid && wr_idx < 4'(COUNT) |=> ent[$past(wr_idx)] == $past(wr_data);
  endproperty
  a_host_store: assert property (p_host_store) else $error("host write lost");

endmodule
`default_nettype wire

/* hdl/calr_access.sv */
// calibration register access over the byte-wide parallel host bus
`timescale 1ns/1ns
`default_nettype none
module calr_access (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // parallel host bus
  input  wire logic                 bus_cs_n,
  input  wire logic                 bus_rd_n,
  input  wire logic                 bus_wr_n,
  input  wire logic                 bus_ctrl_sel,
  input  wire logic                 upper_byte_enable,
  input  wire logic        [7:0]    bus_data_in,
  output logic             [7:0]    bus_data_out,
  output logic                      bus_data_oe,
  // conversion start
  input  wire logic                 convert_start_n,
  output logic                      conv_start,
  // calibration engine
  output logic                      cal_start,
  input  wire logic                 cal_busy,
  input  wire calr_pkg::calr_upd_s  cal_upd,
  // visible state
  output calr_pkg::calr_ctrl_s      ctrl,
  output logic             [3:0]    cal_index
);

  // bus strobe tracking
  logic       wr_act_q;    // write strobe seen last cycle
  logic       rd_act_q;    // read strobe seen last cycle
  logic       wr_upper_byte_enable_q;   // byte lane of current write
  logic       wr_ctrl_q;   // target of current write
  logic       rd_upper_byte_enable_q;   // byte lane of current read
  logic [7:0] wr_data_q;   // data held through the write strobe
  logic [7:0] ctl_lo_hold; // control low byte awaiting commit
  logic [7:0] cal_lo_hold; // correction low byte awaiting commit
  logic       cst_q;       // convert pin last cycle

  // decoded bus activity
  wire logic wr_act = !bus_cs_n && !bus_wr_n;
  wire logic rd_act = !bus_cs_n && !bus_rd_n;
  // a transfer takes effect when its strobe ends
  wire logic wr_end = wr_act_q && !wr_act;
  wire logic rd_end = rd_act_q && !rd_act;

  // control register commit on the high byte
  wire logic ctrl_commit = wr_end && wr_ctrl_q && wr_upper_byte_enable_q;
  // low byte only parks the value, pointer untouched
  wire logic ctl_lo_wr   = wr_end && wr_ctrl_q && !wr_upper_byte_enable_q;
  wire logic cal_lo_wr   = wr_end && !wr_ctrl_q && !wr_upper_byte_enable_q;
  // high byte completes a correction word
  wire logic cal_wr      = wr_end && !wr_ctrl_q && wr_upper_byte_enable_q;

  // high byte read of a correction word finishes it
  wire logic cal_rd_done = rd_end && rd_upper_byte_enable_q && (ctrl.read_sel == calr_pkg::RDSEL_CAL);

  // reads and writes share one pointer; host keeps them apart
  wire logic advance = cal_wr || cal_rd_done;

  // next control fields from the parked low byte
  wire calr_pkg::calr_ctrl_s new_ctrl = '{
    read_sel:  {ctl_lo_hold[calr_pkg::CTL_RDSEL_HI], ctl_lo_hold[calr_pkg::CTL_RDSEL_LO]},
    cal_group: {ctl_lo_hold[calr_pkg::CTL_GRP_HI], ctl_lo_hold[calr_pkg::CTL_GRP_LO]}
  };
  wire calr_pkg::calr_ctrl_s next_ctrl = ctrl_commit ? new_ctrl : ctrl;

  // start requests
  wire logic pin_start  = convert_start_n && !cst_q;
  wire logic soft_start = ctrl_commit && ctl_lo_hold[calr_pkg::CTL_CONV];
  wire logic next_conv  = pin_start || soft_start;
  wire logic next_cal   = ctrl_commit && ctl_lo_hold[calr_pkg::CTL_CAL];

  // correction word at the pointer and the full write word
  wire logic [13:0] cal_rd_data;
  // upper two bits fall away, so stored words are 14 bits
  wire logic [13:0] cal_wr_data = {wr_data_q[5:0], cal_lo_hold};

  // status word: fixed ones, group, busy
  wire logic [15:0] status_word = calr_pkg::ST_ONES
                                | (16'(cal_busy) << calr_pkg::ST_BUSY)
                                | (16'(cal_busy) << calr_pkg::ST_STCAL)
                                | (16'(ctrl.cal_group[1]) << calr_pkg::ST_GRPHI)
                                | (16'(ctrl.cal_group[0]) << calr_pkg::ST_GRPLO);

  // read path selection; other codes belong to other blocks and read zero
  wire logic is_cal_rd = (ctrl.read_sel == calr_pkg::RDSEL_CAL);
  wire logic is_st_rd  = (ctrl.read_sel == calr_pkg::RDSEL_STATUS);
  wire logic [15:0] read_word = is_cal_rd ? {2'b00, cal_rd_data} :
                                is_st_rd  ? status_word : 16'h0000;
  wire logic [7:0]  next_data = upper_byte_enable ? read_word[15:8] : read_word[7:0];

  // pointer over the selected group
  calr_pointer u_ptr (
    .ref_clk (ref_clk),
    .reset   (reset),
    .group   (next_ctrl.cal_group),
    .restart (ctrl_commit),
    .advance (advance),
    .index   (cal_index),
    .at_last ()
  );

  // storage of the ten correction words
  calr_regfile #(
    .COUNT (calr_pkg::CAL_COUNT)
  ) u_regs (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (cal_wr),
    .wr_idx  (cal_index),
    .wr_data (cal_wr_data),
    .upd     (cal_upd),
    .rd_idx  (cal_index),
    .rd_data (cal_rd_data)
  );

  // strobe history
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      cst_q    <= 1'b1;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      cst_q    <= convert_start_n;
    end
  end

  // write strobe capture: last value before the strobe ends counts
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_data_q <= 8'h00;
      wr_upper_byte_enable_q <= 1'b0;
      wr_ctrl_q <= 1'b0;
    end else if (wr_act) begin
      wr_data_q <= bus_data_in;
      wr_upper_byte_enable_q <= upper_byte_enable;
      wr_ctrl_q <= bus_ctrl_sel;
    end
  end

  // read lane capture
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_upper_byte_enable_q <= 1'b0;
    end else if (rd_act) begin
      rd_upper_byte_enable_q <= upper_byte_enable;
    end
  end

  // low byte holding registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_lo_hold <= 8'h00;
      cal_lo_hold <= 8'h00;
    end else begin
      if (ctl_lo_wr) begin
        ctl_lo_hold <= wr_data_q;
      end
      if (cal_lo_wr) begin
        cal_lo_hold <= wr_data_q;
      end
    end
  end

  // control selections; every commit also restarts the pointer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl <= calr_pkg::CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // start pulses, one cycle each
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conv_start <= 1'b0;
      cal_start  <= 1'b0;
    end else begin
      conv_start <= next_conv;
      cal_start  <= next_cal;
    end
  end

  // read data one cycle behind the strobe; quiet bus reads zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_data_out <= 8'h00;
      bus_data_oe  <= 1'b0;
    end else begin
      bus_data_out <= rd_act ? next_data : 8'h00;
      bus_data_oe  <= rd_act;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_top_zero;
    rd_act && upper_byte_enable && is_cal_rd |=> bus_data_oe && bus_data_out[7:6] == 2'b00;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("correction word top bits not zero");

  property p_restart;
    ctrl_commit |=> cal_index == ((ctrl.cal_group == calr_pkg::GRP_OFF) ?
                                  calr_pkg::IDX_OFFSET : calr_pkg::IDX_GAIN);
  endproperty
  a_restart: assert property (p_restart) else $error("pointer not at first word");

  property p_low_holds;
    cal_lo_wr |=> $stable(cal_index);
  endproperty
  a_low_holds: assert property (p_low_holds) else $error("pointer moved on low byte");

  property p_status;
    rd_act && is_st_rd && !upper_byte_enable |=> bus_data_out[7:6] == 2'b11;
  endproperty
  a_status: assert property (p_status) else $error("status word not on read path");

  property p_pin_start;
    $rose(convert_start_n) |=> conv_start ##1 (!conv_start || $past(next_conv));
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("pin start missed");

  property p_soft_start;
    ctrl_commit && ctl_lo_hold[calr_pkg::CTL_CONV] |=> conv_start;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("software start missed");

  property p_full_walk;
    advance && !ctrl_commit && cal_index == calr_pkg::IDX_DAC_LAST |=> cal_index == calr_pkg::IDX_GAIN;
  endproperty
  a_full_walk: assert property (p_full_walk) else $error("full walk did not wrap");

endmodule
`default_nettype wire

/* dv/calr_host.sv */
// host processor model driving the byte-wide parallel bus
`timescale 1ns/1ns
`default_nettype none
module calr_host (
  // clock
  input  wire logic       ref_clk,
  // strobes and selects
  output logic            bus_cs_n,
  output logic            bus_rd_n,
  output logic            bus_wr_n,
  output logic            bus_ctrl_sel,
  output logic            upper_byte_enable,
  // data lines
  output logic      [7:0] bus_data_in,
  input  wire logic [7:0] bus_data_out,
  input  wire logic       bus_data_oe
);
  // bus idle from time zero
  initial begin
    bus_cs_n          = 1'b1;
    bus_rd_n          = 1'b1;
    bus_wr_n          = 1'b1;
    bus_ctrl_sel      = 1'b0;
    upper_byte_enable = 1'b0;
    bus_data_in       = 8'h00;
  end

  // one byte write; released data shows the inverse so stale bytes never match
  task automatic wr(input logic sel, input logic hb, input logic [7:0] d);
    @(posedge ref_clk);
    bus_cs_n          <= 1'b0;
    bus_wr_n          <= 1'b0;
    bus_ctrl_sel      <= sel;
    upper_byte_enable <= hb;
    bus_data_in       <= d;
    @(posedge ref_clk);
    bus_cs_n          <= 1'b1;
    bus_wr_n          <= 1'b1;
    bus_data_in       <= ~d;
    @(posedge ref_clk);
    #1;
  endtask

  // one byte read; data taken one cycle after the strobe is seen
  task automatic rd(input logic hb, output logic [7:0] d, output logic oe);
    @(posedge ref_clk);
    bus_cs_n          <= 1'b0;
    bus_rd_n          <= 1'b0;
    upper_byte_enable <= hb;
    @(posedge ref_clk);
    bus_cs_n          <= 1'b1;
    bus_rd_n          <= 1'b1;
    #1;
    d  = bus_data_out;
    oe = bus_data_oe;
    @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* dv/calr_access_tb.sv */
// self-checking bench for the calibration register access block
`timescale 1ns/1ns
`default_nettype none
module calr_access_tb;
  logic                 ref_clk;           // 20 MHz clock
  logic                 reset;             // async, active high
  logic                 bus_cs_n;          // host bus from model
  logic                 bus_rd_n;
  logic                 bus_wr_n;
  logic                 bus_ctrl_sel;
  logic                 upper_byte_enable;
  logic [7:0]           bus_data_in;
  logic [7:0]           bus_data_out;      // design answers
  logic                 bus_data_oe;
  logic                 convert_start_n;   // conversion pin
  logic                 conv_start;
  logic                 cal_start;
  logic                 cal_busy;          // engine side
  calr_pkg::calr_upd_s  cal_upd;
  calr_pkg::calr_ctrl_s ctrl;
  logic [3:0]           cal_index;
  logic [13:0]          mem [10];          // expected word contents
  logic [7:0]           lo_b;
  logic [7:0]           hi_b;
  logic                 oe_b;
  int                   n_fail;
  int                   total_checks;
  int                   n_conv;            // start pulses seen
  int                   n_cal;
  int                   cycles;

  calr_access uut (.ref_clk(ref_clk), .reset(reset), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n),
    .bus_wr_n(bus_wr_n), .bus_ctrl_sel(bus_ctrl_sel), .upper_byte_enable(upper_byte_enable),
    .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .convert_start_n(convert_start_n), .conv_start(conv_start), .cal_start(cal_start),
    .cal_busy(cal_busy), .cal_upd(cal_upd), .ctrl(ctrl), .cal_index(cal_index));

  calr_host host (.ref_clk(ref_clk), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .bus_ctrl_sel(bus_ctrl_sel), .upper_byte_enable(upper_byte_enable), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe));

  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // pulse counters and hang guard; a stuck handshake ends here
  always @(posedge ref_clk) begin
    cycles++;
    if (conv_start === 1'b1) n_conv++;
    if (cal_start === 1'b1) n_cal++;
    if (cycles == 5000) begin
      n_fail++;
      $display("Error timeout expected finish seen %0d cycles", cycles);
      complete_run();
    end
  end

  // single comparison point
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // control write: low byte parks fields, high byte commits
  task automatic ctl(input logic [1:0] rsel, input logic [1:0] g, input logic [1:0] starts);
    host.wr(1'b1, 1'b0, {2'b00, starts, g, rsel});
    host.wr(1'b1, 1'b1, 8'h00);
  endtask

  // walk one group, writing fresh words or reading them back
  task automatic walk(input logic [1:0] g, input logic wr_mode);
    logic [3:0]  first;
    logic [3:0]  idx;
    logic [1:0]  rsel;
    logic [15:0] v;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic        lo_oe;
    logic        hi_oe;
    int          n;
    first = (g == calr_pkg::GRP_OFF) ? calr_pkg::IDX_OFFSET : calr_pkg::IDX_GAIN;
    n     = (g == calr_pkg::GRP_ALL) ? 10 : (g == calr_pkg::GRP_GAIN_OFF) ? 2 : 1;
    rsel  = wr_mode ? 2'h0 : calr_pkg::RDSEL_CAL;
    ctl(rsel, g, 2'h0);
    chk("ctrl select", {12'h000, rsel, g}, {12'h000, ctrl});
    chk("index after select", {12'h000, first}, {12'h000, cal_index});
    for (int i = 0; i < n; i++) begin
      idx = first + 4'(i);
      if (wr_mode) begin
        // top bits set on purpose: they must not stick
        v = {2'b11, 14'(idx) * 14'h0357 + 14'(g) * 14'h1111 + 14'h00A5};
        host.wr(1'b0, 1'b0, v[7:0]);
        chk("index after low byte", {12'h000, idx}, {12'h000, cal_index});
        host.wr(1'b0, 1'b1, v[15:8]);
        mem[idx] = v[13:0];
      end else begin
        host.rd(1'b0, lo, lo_oe);
        chk("index after low byte", {12'h000, idx}, {12'h000, cal_index});
        host.rd(1'b1, hi, hi_oe);
        chk("word read", {2'b00, mem[idx]}, {hi, lo});
        chk("drive enable", 16'h0003, {14'h0000, lo_oe, hi_oe});
      end
      chk("index after word", {12'h000, (i + 1 == n) ? first : idx + 4'h1}, {12'h000, cal_index});
    end
  endtask

  // summary and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    n_fail = 0;
    total_checks = 0;
    n_conv = 0;
    n_cal = 0;
    cycles = 0;
    reset = 1'b1;
    convert_start_n = 1'b1;
    cal_busy = 1'b0;
    cal_upd = '{valid: 1'b0, index: 4'h0, data: 14'h0000};
    mem[0] = calr_pkg::GAIN_RESET;
    mem[1] = calr_pkg::OFFSET_RESET;
    for (int i = 2; i < 10; i++) mem[i] = calr_pkg::DAC_RESET;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    walk(calr_pkg::GRP_ALL, 1'b0);
    // every group written then read back under the same selection
    for (int g = 0; g < 4; g++) begin
      walk(2'(g), 1'b1);
      walk(2'(g), 1'b0);
    end
    // abort after three words; next control write restarts
    ctl(calr_pkg::RDSEL_CAL, calr_pkg::GRP_ALL, 2'h0);
    for (int i = 0; i < 6; i++) host.rd(1'(i), lo_b, oe_b);
    chk("index mid walk", 16'h0003, {12'h000, cal_index});
    ctl(calr_pkg::RDSEL_CAL, calr_pkg::GRP_ALL, 2'h0);
    chk("index after abort", 16'h0000, {12'h000, cal_index});
    // status path with engine busy; pins move only on a clock edge
    @(posedge ref_clk);
    cal_busy <= 1'b1;
    ctl(calr_pkg::RDSEL_STATUS, calr_pkg::GRP_GAIN_OFF, 2'h0);
    host.rd(1'b0, lo_b, oe_b);
    host.rd(1'b1, hi_b, oe_b);
    chk("status word", calr_pkg::ST_ONES | 16'h0013, {hi_b, lo_b});
    // conversion from the pin, then from software
    @(posedge ref_clk);
    cal_busy <= 1'b0;
    convert_start_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    convert_start_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("pin conversion starts", 16'h0001, 16'(n_conv));
    ctl(calr_pkg::RDSEL_CAL, calr_pkg::GRP_ALL, 2'h1);
    repeat (2) @(posedge ref_clk);
    chk("soft conversion starts", 16'h0002, 16'(n_conv));
    ctl(calr_pkg::RDSEL_CAL, calr_pkg::GRP_ALL, 2'h2);
    repeat (2) @(posedge ref_clk);
    chk("calibration starts", 16'h0001, 16'(n_cal));
    // engine rewrites one dac word without the host
    cal_upd <= '{valid: 1'b1, index: 4'h5, data: 14'h1234};
    @(posedge ref_clk);
    cal_upd <= '{valid: 1'b0, index: 4'h0, data: 14'h0000};
    mem[5] = 14'h1234;
    walk(calr_pkg::GRP_ALL, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
